// >>> dv/readout_host.sv
// readout host model: drains the capture stream into a word array
// assumes words arrive as a valid/ready stream on the sample clock
module readout_host
   import capture_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  srst,
   input  wire logic  clr,
   input  wire logic  slow,
   input  wire slot_t out_word,
   input  wire logic  out_valid,
   output logic       out_ready,
   output int         n_words,
   output slot_t      words [DEPTH_DEF]
);
   timeunit 1ns;
   timeprecision 1ps;

   // host reads out
   // slow mode stalls every other cycle so the buffer must hold words
   always_ff @(posedge clock) begin
      if (srst || clr) begin
         n_words   <= 0;
         out_ready <= 1'b0;
      end else begin
         if (out_valid && out_ready && n_words < DEPTH_DEF) begin
            words[n_words] <= out_word;
            n_words        <= n_words + 1;
         end
         out_ready <= slow ? ~out_ready : 1'b1;
      end
   end
endmodule

// >>> dv/segmented_capture_trigger_sequencer_tb_top.sv
// testbench of the capture sequencer, one task per scenario
// assumes readout_host as the far side and a 64-slot buffer
module segmented_capture_trigger_sequencer_tb_top
   import capture_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock, srst, init_cmd, sample_clk_level, trig_in_met;
   logic       seg_trig, store_qual, out_valid, out_ready, clr, slow;
   acq_cfg_t   cfg;
   flow_in_t   flow_in;
   logic [6:0] seg_limit, seg_len, active_seg;
   logic [1:0] last_level, level_met;
   logic [7:0] probe;
   logic [3:0] trig_cond;
   logic [5:0] mark_addr;
   slot_t      out_word;
   acq_state_t status;
   int         n_words, n_fail, check_count;
   slot_t      words [DEPTH_DEF];

   capture_sequencer i_dut (.clock(clock), .srst(srst), .cfg(cfg), .flow_in(flow_in),
      .seg_limit(seg_limit), .seg_len(seg_len), .last_level(last_level), .probe(probe),
      .sample_clk_level(sample_clk_level), .init_cmd(init_cmd), .trig_in_met(trig_in_met),
      .trig_cond(trig_cond), .seg_trig(seg_trig), .store_qual(store_qual),
      .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready), .status(status),
      .level_met(level_met), .active_seg(active_seg), .mark_addr(mark_addr));

   readout_host i_host (.clock(clock), .srst(srst), .clr(clr), .slow(slow),
      .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready),
      .n_words(n_words), .words(words));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // probe counts up so every sample tells its own capture cycle
   always @(posedge clock) probe <= srst ? 8'h00 : probe + 8'h01;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // bounded wait; running out ends the run
   task automatic wait_st(input acq_state_t st, input int lim);
      int k;
      k = 0;
      while (status !== st && k < lim) begin
         tick(1);
         k++;
      end
      if (status !== st) begin
         check(status, st, "state wait timeout");
         stop_test();
      end
   endtask

   function automatic int cnt(input int lo, input int len, input bit mk);
      int s;
      s = 0;
      for (int i = lo; i < lo + len; i++) begin
         if ((mk ? words[i].mark : words[i].written) === 1'b1) begin
            s++;
         end
      end
      return s;
   endfunction

   task automatic start_run(input acq_cfg_t c);
      @(posedge clock);
      cfg      <= c;
      clr      <= 1'b1;
      @(posedge clock);
      init_cmd <= 1'b1;
      clr      <= 1'b0;
      @(posedge clock);
      init_cmd <= 1'b0;
      wait_st(S_WAIT_CLK, DEPTH_DEF + 4);
      tick(5);
      check(status, S_WAIT_CLK, "left clock wait early");
      @(posedge clock);
      sample_clk_level <= ~sample_clk_level;
      tick(1);
   endtask

   task automatic finish_run();
      wait_st(S_OFFLOAD, 300);
      wait_st(S_IDLE, 400);
      check(n_words, DEPTH_DEF, "words read out");
   endtask

   task automatic run_nonseg(input post_sel_t sel, input int p);
      int m;
      start_run('{1'b0, 1'b0, 1'b0, 1'b0, sel});
      wait_st(S_PREFILL, 3);
      @(posedge clock);
      trig_cond <= 4'h3;
      tick(30);
      check(status, S_PREFILL, "trigger during prefill");
      @(posedge clock);
      trig_cond <= 4'h2;
      wait_st(S_WAIT_TRIG, 70);
      tick(3);
      check(status, S_WAIT_TRIG, "level out of order fired");
      @(posedge clock);
      trig_cond <= 4'h1;
      @(posedge clock);
      trig_cond <= 4'h2;
      @(posedge clock);
      trig_cond <= 4'h0;
      wait_st(S_POST, 3);
      finish_run();
      m = 0;
      for (int i = 0; i < DEPTH_DEF; i++) begin
         if (words[i].mark === 1'b1) begin
            m = i;
         end
      end
      check(cnt(0, DEPTH_DEF, 1), 1, "trigger marks");
      check(cnt(0, DEPTH_DEF, 0), DEPTH_DEF, "full buffer");
      check(words[(m + p) % DEPTH_DEF].data, 8'(words[m].data + p), "last post");
      check(words[(m + p + 1) % DEPTH_DEF].data, 8'(words[m].data + p + 1 - DEPTH_DEF), "oldest");
   endtask

   task automatic run_qual();
      @(posedge clock);
      store_qual  <= 1'b1;
      trig_in_met <= 1'b0;
      trig_cond   <= 4'h3;
      start_run('{1'b0, 1'b0, 1'b1, 1'b1, POST_50});
      wait_st(S_WAIT_TIN, 3);
      tick(8);
      check(status, S_WAIT_TIN, "levels before trigger-in");
      @(posedge clock);
      trig_in_met <= 1'b1;
      trig_cond   <= 4'h1;
      wait_st(S_WAIT_TRIG, 3);
      @(posedge clock);
      trig_cond   <= 4'h2;
      wait_st(S_POST, 3);
      @(posedge clock);
      trig_cond   <= 4'h0;
      finish_run();
      check(cnt(0, DEPTH_DEF, 1), 1, "trigger marks");
      check(cnt(0, DEPTH_DEF, 0) < DEPTH_DEF, 1, "blank slots");
   endtask

   // custom flow: both flags masked first, then two counted segments and a final trigger
   task automatic run_custom();
      @(posedge clock);
      seg_limit <= 7'h01;
      seg_len   <= 7'h07;
      flow_in   <= '{1'b1, 1'b1, 1'b0, 1'b0};
      start_run('{1'b0, 1'b1, 1'b0, 1'b0, POST_12});
      tick(6);
      check(status, S_WAIT_TRIG, "masked flow fired");
      @(posedge clock);
      flow_in.state_enable_flag_b <= 1'b1;
      wait_st(S_POST, 40);
      // two segments of eight stored samples each, then the trigger point
      check(mark_addr, 6'h10, "flow trigger point");
      finish_run();
      check(cnt(0, DEPTH_DEF, 1), 2, "segment close marks");
      check(cnt(0, DEPTH_DEF, 0), 24, "stored samples");
      @(posedge clock);
      flow_in   <= '0;
   endtask

   task automatic run_seg(input int m, input int n, input post_sel_t sel);
      @(posedge clock);
      seg_limit <= 7'(m);
      seg_len   <= 7'(n);
      seg_trig  <= 1'b1;
      slow      <= 1'b1;
      start_run('{1'b1, 1'b0, 1'b0, 1'b0, sel});
      wait_st(S_OFFLOAD, 200);
      check(active_seg, m - 1, "last segment reached");
      finish_run();
      for (int i = 0; i < m; i++) begin
         // earlier segments are cut to one sample, the last is post only
         check(cnt(i * n, n, 0), (i == m - 1) ? n - ((n * PRE_MUL) >> PRE_SHIFT) : 1, "written");
         check(cnt(i * n, n, 1), 1, "segment mark");
      end
      @(posedge clock);
      seg_trig  <= 1'b0;
      slow      <= 1'b0;
   endtask

   initial begin
      srst = 1'b1;
      cfg = '0;
      flow_in = '0;
      init_cmd = 1'b0;
      sample_clk_level = 1'b0;
      trig_in_met = 1'b0;
      seg_trig = 1'b0;
      store_qual = 1'b0;
      clr = 1'b0;
      slow = 1'b0;
      seg_limit = 7'h04;
      seg_len = 7'h10;
      last_level = 2'h1;
      trig_cond = 4'h0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      tick(5);
      check(status, S_IDLE, "idle without start");
      run_nonseg(POST_12, 8);
      run_nonseg(POST_50, 32);
      run_nonseg(POST_88, 56);
      run_qual();
      run_custom();
      run_seg(4, 16, POST_12);
      run_seg(2, 32, POST_88);
      stop_test();
   end
endmodule

// >>> hw/capture_pkg.sv
// shared types and constants of the segmented capture and trigger sequencer
// assumes one sample clock; every input is synchronous to it
package capture_pkg;
   localparam int DATA_W     = 8;
   localparam int DEPTH_DEF  = 64;
   localparam int LEVELS_DEF = 4;
   localparam int SEGS_DEF   = 4;
   localparam int SEGLEN_DEF = 16;
   // post-trigger shares of the whole buffer, in percent, rounded
   localparam int PCT_12     = 12;
   localparam int PCT_50     = 50;
   localparam int PCT_88     = 88;
   localparam int PCT_ROUND  = 50;
   localparam int PCT_FULL   = 100;
   // pre-trigger slots of a segment: about one tenth, as len*13/128
   localparam int PRE_MUL    = 13;
   localparam int PRE_SHIFT  = 7;

   typedef enum logic [1:0] {
      POST_12 = 2'h0,
      POST_50 = 2'h1,
      POST_88 = 2'h2
   } post_sel_t;

   typedef enum logic [7:0] {
      S_IDLE      = 8'h01,
      S_CLEAR     = 8'h02,
      S_WAIT_CLK  = 8'h04,
      S_PREFILL   = 8'h08,
      S_WAIT_TIN  = 8'h10,
      S_WAIT_TRIG = 8'h20,
      S_POST      = 8'h40,
      S_OFFLOAD   = 8'h80
   } acq_state_t;

   typedef enum logic [2:0] {
      F_A = 3'h1,
      F_B = 3'h2,
      F_C = 3'h4
   } flow_state_t;

   localparam acq_state_t  ST_RST   = S_IDLE;
   localparam flow_state_t FLOW_RST = F_A;

   typedef struct packed {
      logic      segmented;
      logic      custom;
      logic      qualified;
      logic      tin_en;
      post_sel_t post_sel;
   } acq_cfg_t;

   typedef struct packed {
      logic cond_a;
      logic cond_b;
      logic state_enable_flag_a;
      logic state_enable_flag_b;
   } flow_in_t;

   typedef struct packed {
      logic              written;
      logic              mark;
      logic [DATA_W-1:0] data;
   } slot_t;
endpackage

// >>> hw/capture_sequencer.sv
// acquisition and trigger sequencing core of an on-chip logic analyzer
// assumes host commands arrive as synchronous levels and readout is a
// valid/ready stream that the debug chain drains
// Overview of operation
// - segmented mode captures one segment after another, each circular while active
// - a finished segment hands over to the next segment's fresh acquisition
// - after a segment trigger the next segment's trigger is watched at once
// - next segment starts at post-fill end or next trigger, whichever first
// - every slot carries a written bit so unwritten slots read as blank
// - a segment keeps about ten percent before and ninety after its trigger
// - a segment triggered on entry holds post data only, pre slots stay blank
// - segmented mode ignores the whole-buffer post-trigger share unless custom flow is on
// - non-segmented mode takes 12, 50 or 88 percent after the trigger
// - continuous non-segmented mode fills the buffer before triggers count
// - with trigger-in enabled, trigger levels wait for trigger-in
// - trigger levels match strictly in order, the last one fires
// - acquisition waits until the watched sample clock toggles
// - after acquisition the buffer is streamed out to the host
// - between runs the block idles until the host's start command
// - segment triggers come from sequential flow or custom state flow
// - segment count and samples per segment are runtime inputs
// - host-set enable flags gate custom flow states
// - a build option fixes segment count and length as constants
// - segmented or qualified capture evaluates triggers while writing
module capture_sequencer
   import capture_pkg::*;
#(
   parameter int       DEPTH       = DEPTH_DEF,
   parameter int       LEVELS      = LEVELS_DEF,
   parameter bit       RUNTIME_CFG = 1'b1,
   parameter int       FIXED_SEGS  = SEGS_DEF,
   parameter int       FIXED_LEN   = SEGLEN_DEF,
   parameter int       AW          = $clog2(DEPTH),
   parameter int       CW          = AW + 1,
   parameter int       LW          = $clog2(LEVELS)
) (
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire capture_pkg::acq_cfg_t   cfg,
   input  wire capture_pkg::flow_in_t   flow_in,
   input  wire logic [CW-1:0]           seg_limit,
   input  wire logic [CW-1:0]           seg_len,
   input  wire logic [LW-1:0]           last_level,
   input  wire logic [capture_pkg::DATA_W-1:0] probe,
   input  wire logic                    sample_clk_level,
   input  wire logic                    init_cmd,
   input  wire logic                    trig_in_met,
   input  wire logic [LEVELS-1:0]       trig_cond,
   input  wire logic                    seg_trig,
   input  wire logic                    store_qual,
   output capture_pkg::slot_t           out_word,
   output logic                         out_valid,
   input  wire logic                    out_ready,
   output capture_pkg::acq_state_t      status,
   output logic [LW-1:0]                level_met,
   output logic [CW-1:0]                active_seg,
   output logic [AW-1:0]                mark_addr
);
   import capture_pkg::*;

   localparam logic [AW-1:0] LAST_A  = AW'(DEPTH - 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] POST_A  = CW'((DEPTH * PCT_12 + PCT_ROUND) / PCT_FULL);
   localparam logic [CW-1:0] POST_B  = CW'((DEPTH * PCT_50 + PCT_ROUND) / PCT_FULL);
   localparam logic [CW-1:0] POST_C  = CW'((DEPTH * PCT_88 + PCT_ROUND) / PCT_FULL);

   typedef struct packed {
      acq_state_t    st;
      flow_state_t   flow;
      logic [LW-1:0] level;
      logic [CW-1:0] seg_idx;
      logic [AW-1:0] base;
      logic [AW-1:0] off;
      logic [CW-1:0] post_left;
      logic [CW-1:0] fill;
      logic [CW-1:0] seg_cnt;
      logic [CW-1:0] samp_cnt;
      logic          store_en;
      logic          prev_clk;
      logic [CW-1:0] rd_addr;
      logic          rd_pend;
      slot_t         b0;
      slot_t         b1;
      logic [1:0]    cnt;
      logic [AW-1:0] mark;
   } state_t;

   state_t        s_r;
   state_t        s_nxt;
   logic          we;
   logic [AW-1:0] waddr;
   slot_t         wdata;
   logic          re;
   slot_t         rdata;
   logic [CW-1:0] m_lim;
   logic [CW-1:0] n_len;
   logic [CW-1:0] pre_len;
   logic [CW-1:0] seg_post;
   logic [CW-1:0] seg_left;
   logic [CW-1:0] whole_post;
   logic [CW-1:0] len_eff;
   logic [2*CW-1:0] pre_prod;
   logic          last_seg;
   logic          acquiring;
   logic          gate;
   logic          pop;
   logic          trig_evt;
   logic          final_trig;
   logic          seg_close;
   logic [2:0]    occ;

   // limits either from the host or frozen at build time to save area
   // frozen limits
   assign m_lim = RUNTIME_CFG ? seg_limit : CW'(FIXED_SEGS);
   assign n_len = RUNTIME_CFG ? seg_len : CW'(FIXED_LEN);

   // segment split; a multiply by constant avoids a divider
   // ten percent pre
   assign pre_prod = (n_len * CW'(PRE_MUL)) >> PRE_SHIFT;
   assign pre_len  = pre_prod[CW-1:0];
   assign seg_post = n_len - pre_len;
   // the marked trigger write is the first post sample and the count ends at zero, hence seg_post minus two
   assign seg_left = (seg_post > CW'(1)) ? seg_post - CW'(2) : '0;
   assign last_seg = (s_r.seg_idx == m_lim - 1'b1);
   assign len_eff  = cfg.segmented ? n_len : DEPTH_C;

   // whole-buffer post share, used outside segmented mode and by the custom flow
   // post share
   always_comb begin
      case (cfg.post_sel)
         POST_12: whole_post = POST_A;
         POST_50: whole_post = POST_B;
         POST_88: whole_post = POST_C;
         default: whole_post = POST_A;
      endcase
   end

   // write gate: flow command, storage qualifier, or always
   assign acquiring = s_r.st inside {S_PREFILL, S_WAIT_TIN, S_WAIT_TRIG, S_POST};
   assign gate = cfg.custom ? s_r.store_en : (cfg.qualified ? store_qual : 1'b1);
   assign pop  = out_valid && out_ready;
   assign occ  = {1'b0, s_r.cnt} + {2'b00, s_r.rd_pend};

   // next state of the whole block
   always_comb begin
      s_nxt      = s_r;
      trig_evt   = 1'b0;
      final_trig = 1'b0;
      seg_close  = 1'b0;
      re         = 1'b0;
      we         = acquiring && gate;
      waddr      = s_r.base + s_r.off;
      if (we) begin
         // circular within the active segment or the whole buffer
         // circular segment
         s_nxt.off = (s_r.off == AW'(len_eff - 1'b1)) ? '0 : s_r.off + 1'b1;
      end
      // custom flow engine, runs while triggers are being evaluated
      if (s_r.st == S_WAIT_TRIG && cfg.custom) begin
         case (s_r.flow)
            F_A: begin
               if (flow_in.cond_b && flow_in.state_enable_flag_a) begin
                  s_nxt.store_en = 1'b1;
                  final_trig     = 1'b1;
               end else if (!flow_in.state_enable_flag_a) begin
                  s_nxt.flow = F_B;
               end
            end
            F_B: begin
               if (flow_in.cond_a && s_r.seg_cnt <= m_lim && flow_in.state_enable_flag_b) begin
                  s_nxt.store_en = 1'b1;
                  s_nxt.seg_cnt  = s_r.seg_cnt + 1'b1;
                  s_nxt.flow     = F_C;
               end else if (s_r.seg_cnt > m_lim) begin
                  s_nxt.store_en = 1'b1;
                  final_trig     = 1'b1;
               end
            end
            F_C: begin
               if (s_r.samp_cnt >= n_len) begin
                  s_nxt.samp_cnt = '0;
                  s_nxt.store_en = 1'b0;
                  seg_close      = 1'b1;
                  s_nxt.flow     = F_A;
               end else begin
                  s_nxt.samp_cnt = s_r.samp_cnt + 1'b1;
               end
            end
            default: s_nxt.flow = FLOW_RST;
         endcase
      end
      case (s_r.st)
         S_IDLE: begin
            if (init_cmd) begin
               s_nxt.st      = S_CLEAR;
               s_nxt.rd_addr = '0;
            end
         end
         S_CLEAR: begin
            we            = 1'b1;
            waddr         = s_r.rd_addr[AW-1:0];
            s_nxt.rd_addr = s_r.rd_addr + 1'b1;
            s_nxt.off     = '0;
            s_nxt.base    = '0;
            s_nxt.seg_idx = '0;
            s_nxt.level   = '0;
            s_nxt.fill    = '0;
            s_nxt.flow    = FLOW_RST;
            s_nxt.store_en = 1'b0;
            s_nxt.seg_cnt = '0;
            s_nxt.samp_cnt = '0;
            s_nxt.prev_clk = sample_clk_level;
            if (s_r.rd_addr[AW-1:0] == LAST_A) begin
               s_nxt.st = S_WAIT_CLK;
            end
         end
         S_WAIT_CLK: begin
            s_nxt.prev_clk = sample_clk_level;
            if (sample_clk_level != s_r.prev_clk) begin
               if (!cfg.segmented && !cfg.custom && !cfg.qualified) begin
                  s_nxt.st = S_PREFILL;
               end else begin
                  s_nxt.st = cfg.tin_en ? S_WAIT_TIN : S_WAIT_TRIG;
               end
            end
         end
         S_PREFILL: begin
            s_nxt.fill = s_r.fill + 1'b1;
            if (s_r.fill == DEPTH_C - 1'b1) begin
               s_nxt.st = cfg.tin_en ? S_WAIT_TIN : S_WAIT_TRIG;
            end
         end
         S_WAIT_TIN: begin
            if (trig_in_met) begin
               s_nxt.st = S_WAIT_TRIG;
            end
         end
         S_WAIT_TRIG: begin
            if (cfg.custom) begin
               trig_evt = final_trig || seg_close;
               if (final_trig) begin
                  s_nxt.st        = S_POST;
                  s_nxt.post_left = whole_post - 1'b1;
               end
            end else if (cfg.segmented) begin
               if (seg_trig) begin
                  trig_evt        = 1'b1;
                  s_nxt.st        = S_POST;
                  s_nxt.post_left = seg_left;
               end
            end else if (trig_cond[s_r.level]) begin
               if (s_r.level == last_level) begin
                  trig_evt        = 1'b1;
                  s_nxt.st        = S_POST;
                  s_nxt.post_left = whole_post - 1'b1;
               end else begin
                  s_nxt.level = s_r.level + 1'b1;
               end
            end
         end
         S_POST: begin
            if (cfg.segmented && !cfg.custom && seg_trig && !last_seg) begin
               trig_evt        = 1'b1;
               waddr           = s_r.base + AW'(n_len);
               s_nxt.base      = s_r.base + AW'(n_len);
               s_nxt.off       = AW'(1);
               s_nxt.seg_idx   = s_r.seg_idx + 1'b1;
               s_nxt.post_left = seg_left;
               if (seg_post == CW'(1)) begin
                  s_nxt.off = '0;
               end
            end else if (we) begin
               s_nxt.post_left = s_r.post_left - 1'b1;
               if (s_r.post_left == '0) begin
                  if (cfg.segmented && !cfg.custom && !last_seg) begin
                     s_nxt.st      = S_WAIT_TRIG;
                     s_nxt.base    = s_r.base + AW'(n_len);
                     s_nxt.off     = '0;
                     s_nxt.seg_idx = s_r.seg_idx + 1'b1;
                  end else begin
                     s_nxt.st      = S_OFFLOAD;
                     s_nxt.rd_addr = '0;
                  end
               end
            end
         end
         S_OFFLOAD: begin
            if (s_r.rd_addr != DEPTH_C && (occ < 3'h2 || (occ == 3'h2 && pop))) begin
               re            = 1'b1;
               s_nxt.rd_addr = s_r.rd_addr + 1'b1;
            end
            if (s_r.rd_addr == DEPTH_C && !s_r.rd_pend && s_r.cnt == 2'h0) begin
               s_nxt.st = S_IDLE;
            end
         end
         default: s_nxt.st = ST_RST;
      endcase
      if (trig_evt) begin
         s_nxt.mark = waddr;
      end
      // two-entry buffer; reads stall while it cannot take a word
      s_nxt.rd_pend = re;
      if (pop) begin
         s_nxt.b0  = s_r.b1;
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      if (s_r.rd_pend) begin
         if (s_nxt.cnt == 2'h0) begin
            s_nxt.b0 = rdata;
         end else begin
            s_nxt.b1 = rdata;
         end
         s_nxt.cnt = s_nxt.cnt + 1'b1;
      end
   end

   // slot content; a cleared slot has written low
   always_comb begin
      wdata = '0;
      if (s_r.st != S_CLEAR) begin
         wdata.written = 1'b1;
         wdata.mark    = trig_evt;
         wdata.data    = probe;
      end
   end

   // single register of all block state
   always_ff @(posedge clock) begin
      if (srst) begin
         s_r       <= '0;
         s_r.st    <= ST_RST;
         s_r.flow  <= FLOW_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   slot_mem #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clock (clock),
      .we    (we),
      .waddr (waddr),
      .wdata (wdata),
      .re    (re),
      .raddr (s_r.rd_addr[AW-1:0]),
      .rdata (rdata)
   );

   assign out_word   = s_r.b0;
   assign out_valid  = (s_r.cnt != 2'h0);
   assign status     = s_r.st;
   assign level_met  = s_r.level;
   assign active_seg = s_r.seg_idx;
   assign mark_addr  = s_r.mark;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_stall;
      out_valid && !out_ready;
   endsequence
   sequence s_seg_fire;
      s_r.st == S_WAIT_TRIG && cfg.segmented && !cfg.custom && seg_trig;
   endsequence

   property p_idle_hold;
      s_r.st == S_IDLE && !init_cmd |=> s_r.st == S_IDLE;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("left idle without start");
   property p_wait_clk;
      s_r.st == S_WAIT_CLK && sample_clk_level == s_r.prev_clk |=> s_r.st == S_WAIT_CLK;
   endproperty
   a_wait_clk: assert property (p_wait_clk) else $error("left clock wait early");
   property p_tin;
      s_r.st == S_WAIT_TIN && !trig_in_met |=> s_r.st == S_WAIT_TIN && s_r.level == '0;
   endproperty
   a_tin: assert property (p_tin) else $error("levels before trigger-in");
   property p_level;
      s_r.st == S_WAIT_TRIG && !cfg.segmented && !cfg.custom && trig_cond[s_r.level]
         && s_r.level != last_level |=> s_r.level == $past(s_r.level) + 1'b1;
   endproperty
   a_level: assert property (p_level) else $error("level not stepped");
   property p_prefill;
      s_r.st == S_PREFILL && s_r.fill < DEPTH_C - 1'b1 |=> s_r.st == S_PREFILL;
   endproperty
   a_prefill: assert property (p_prefill) else $error("trigger before full buffer");
   property p_preempt;
      s_r.st == S_POST && cfg.segmented && !cfg.custom && seg_trig && !last_seg
         |=> s_r.st == S_POST && s_r.seg_idx == $past(s_r.seg_idx) + 1'b1;
   endproperty
   a_preempt: assert property (p_preempt) else $error("next trigger did not preempt");
   property p_seg_post;
      s_seg_fire |=> s_r.st == S_POST && s_r.post_left == seg_left;
   endproperty
   a_seg_post: assert property (p_seg_post) else $error("segment post count wrong");
   property p_whole_end;
      s_r.st == S_POST && !cfg.segmented && we && s_r.post_left == '0 |=> s_r.st == S_OFFLOAD;
   endproperty
   a_whole_end: assert property (p_whole_end) else $error("post fill did not end");
   property p_store;
      s_r.st == S_WAIT_TRIG && cfg.custom && s_r.flow == F_C && s_r.samp_cnt >= n_len
         |=> !s_r.store_en && s_r.samp_cnt == '0 && !we;
   endproperty
   a_store: assert property (p_store) else $error("store stop not applied");
   property p_stall;
      s_stall |=> out_valid && $stable(out_word);
   endproperty
   a_stall: assert property (p_stall) else $error("word lost under stall");
endmodule

// >>> hw/slot_mem.sv
// sample memory of the capture buffer, one slot_t per address
// assumes one write and one read port, read data registered
module slot_mem
   import capture_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEF,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          clock,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire slot_t         wdata,
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   output slot_t              rdata
);
   slot_t mem [DEPTH];

   // plain ram: no reset so it maps to block memory
   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule
